// >>> verilog/plpsc_pkg.sv
package plpsc_pkg;

  localparam longint CLK_PERIOD_PS = 64'd4000;

  // link and sequencing times in ns
  localparam longint T_PPG_NS   = 64'd45000000;
  localparam longint T_CLKPR_NS = 64'd20000;
  localparam longint T_PGTRN_NS = 64'd20000000;
  localparam longint T_PGCFG_NS = 64'd100000000;
  localparam longint T_PGRES_NS = 64'd100100000;

  // least times round up, longest round down
  localparam int unsigned PPG_CYC   = 32'(T_PPG_NS * 1000 / CLK_PERIOD_PS);
  localparam int unsigned CLKPR_CYC = 32'((T_CLKPR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned PGTRN_CYC = 32'((T_PGTRN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned PGCFG_CYC = 32'((T_PGCFG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned PGRES_CYC = 32'((T_PGRES_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PMCSR  = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_LAT    = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // field positions
  localparam int unsigned CTRL_ASPM_LSB = 0;
  localparam int unsigned CTRL_PME_BIT  = 2;
  localparam int unsigned CTRL_WAKE_BIT = 3;
  localparam int unsigned CMD_IO_BIT    = 0;
  localparam int unsigned CMD_MEM_BIT   = 1;
  localparam int unsigned LAT_L1_LSB    = 16;

  // reset values and codes
  localparam logic [1:0] ASPM_RST = 2'h0;
  localparam logic [1:0] PS_D0    = 2'h0;
  localparam logic [1:0] PS_D3    = 2'h3;

  typedef enum logic [3:0] {
    FULL_POWER_UNINITIALISED = 4'h1,
    FULL_POWER_ACTIVE        = 4'h2,
    DSTATE_D3                = 4'h4,
    HELD_IN_RESET_STATE      = 4'h8
  } plpsc_dstate_t;

  typedef enum logic [4:0] {
    LINK_L0  = 5'h01,
    LINK_L0S = 5'h02,
    LINK_L1  = 5'h04,
    LINK_L2  = 5'h08,
    LINK_L3  = 5'h10
  } plpsc_lstate_t;

  typedef struct packed {
    logic internal_link_power_ok;
    logic phy_reset;
    logic link_train;
    logic cfg_accept;
    logic cfg_resp;
  } plpsc_seq_t;

endpackage

// >>> verilog/plpsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module plpsc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  if (W < 1)
  begin : g_chk
    $error("plpsc_sync: W must be at least 1");
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= '0;
      q_r    <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end

  assign q_o = q_r;

endmodule
`default_nettype wire

// >>> verilog/plpsc_delay.sv
`timescale 1ns/1ps
`default_nettype none
module plpsc_delay #(
  parameter int unsigned CYC = 1
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  output logic      done_o
);

  localparam int unsigned CW = $clog2(CYC + 1);

  logic [CW-1:0] cnt_r;
  logic          done_r;
  wire logic     at_end;

  if (CYC < 1)
  begin : g_chk
    $error("plpsc_delay: CYC must be at least 1");
  end

  // done rises CYC edges after run rises
  assign at_end = (cnt_r == CW'(CYC - 1));

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i || !run_i)
    begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      if (!done_r)
        cnt_r <= cnt_r + 1'b1;
      done_r <= done_r | at_end;
    end
  end

  assign done_o = done_r;

endmodule
`default_nettype wire

// >>> verilog/plpsc_ctrl.sv
// Contract
// R1: D0 states hold link in L0
// R2: L0s used in both D0 states when idle
// R3: L1 after long idle; L1 in D3
// R4: reset from D3 with PME uses L2
// R5: other reset entries use L3
// R6: ASPM field resets to 00 each reset
// R7: idle beyond L0s latency enters L0s
// R8: L0s held for L1 latency enters L1
// R9: power-state write 11 moves to D3
// R10: host writes 00 to leave D3
// R11: access enable write activates function
// R12: host may delay enable; stay uninitialised
// R13: LAN power good after supplies, osc, delay
// R14: host keeps refclock, power stable before release; host model raises refclock stable 3 cycles after release
// R15: internal power ok after clock and delay
// R16: link training after training delay
// R17: config accept and response after delays
// R18: reset pin low enters reset state
// R19: reset pin release enters uninitialised
// R20: power ok rise resets PHY, stops wake
// R21: traffic restarts idle timers, returns L0
// R22: enables ignored in D3
`timescale 1ns/1ps
`default_nettype none
module plpsc_ctrl #(
  parameter int unsigned LAT_W     = 16,
  parameter int unsigned PPG_CYC   = plpsc_pkg::PPG_CYC,
  parameter int unsigned CLKPR_CYC = plpsc_pkg::CLKPR_CYC,
  parameter int unsigned PGTRN_CYC = plpsc_pkg::PGTRN_CYC,
  parameter int unsigned PGCFG_CYC = plpsc_pkg::PGCFG_CYC,
  parameter int unsigned PGRES_CYC = plpsc_pkg::PGRES_CYC
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic      [31:0]          hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  input  wire logic                 host_fundamental_reset_n_i,
  input  wire logic                 supplies_good_i,
  input  wire logic                 osc_stable_i,
  input  wire logic                 pcie_clk_stable_i,
  input  wire logic [LAT_W-1:0]     idle_to_standby_latency_i,
  input  wire logic [LAT_W-1:0]     standby_to_sleep_latency_i,
  input  wire logic                 link_traffic_i,
  output logic                      lan_power_good_o,
  output plpsc_pkg::plpsc_seq_t     seq_o,
  output plpsc_pkg::plpsc_dstate_t  dstate_o,
  output plpsc_pkg::plpsc_lstate_t  lstate_o,
  output logic                      link_ready_o,
  output logic                      phy_full_power_o,
  output logic                      wake_enable_o
);

  if (LAT_W < 1 || LAT_W > 16)
  begin : g_chk
    $error("plpsc_ctrl: LAT_W must be 1 to 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and reset edge

  wire logic [3:0] pins_s;
  wire logic       hrst_s;
  wire logic       supply_s;
  wire logic       osc_s;
  wire logic       clk_ok_s;
  logic            hrst_prev_r;
  wire logic       hrst_rise;
  wire logic       cfg_rst;

  plpsc_sync #(
    .W (4)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({host_fundamental_reset_n_i, supplies_good_i, osc_stable_i, pcie_clk_stable_i}),
    .q_o     (pins_s)
  );

  assign hrst_s    = pins_s[3];
  assign supply_s  = pins_s[2];
  assign osc_s     = pins_s[1];
  assign clk_ok_s  = pins_s[0];
  assign hrst_rise = hrst_s & ~hrst_prev_r;
  assign cfg_rst   = ~rst_n_i | ~hrst_s;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic [7:0]  dph_addr_r;
  logic        dph_wr_r;
  logic [31:0] hrdata_r;
  wire logic   aph;
  wire logic   wr_ctrl;
  wire logic   wr_pmcsr;
  wire logic   wr_cmd;
  wire logic [31:0] rd_word;

  logic [1:0]  aspm_r;
  logic        pme_en_r;
  logic        wake_en_r;
  logic        io_en_r;
  logic        mem_en_r;

  assign aph      = hsel_i & htrans_i[1] & hready_i;
  assign wr_ctrl  = dph_wr_r & (dph_addr_r == plpsc_pkg::OFS_CTRL);
  assign wr_pmcsr = dph_wr_r & (dph_addr_r == plpsc_pkg::OFS_PMCSR);
  assign wr_cmd   = dph_wr_r & (dph_addr_r == plpsc_pkg::OFS_CMD);

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      dph_addr_r <= 8'h00;
      dph_wr_r   <= 1'b0;
      hrdata_r   <= 32'h0000_0000;
    end
    else
    begin
      dph_addr_r <= haddr_i[7:0];
      dph_wr_r   <= aph & hwrite_i;
      if (aph && !hwrite_i)
        hrdata_r <= rd_word;
    end
  end

  assign hrdata_o    = hrdata_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // function power state

  plpsc_pkg::plpsc_dstate_t dstate_r;
  plpsc_pkg::plpsc_dstate_t dstate_nxt;
  logic                     go_l2_r;
  wire logic                in_d0;
  wire logic                ps_d3_wr;
  wire logic                ps_d0_wr;
  wire logic                en_wr;

  assign in_d0    = (dstate_r == plpsc_pkg::FULL_POWER_UNINITIALISED) |
                    (dstate_r == plpsc_pkg::FULL_POWER_ACTIVE);
  assign ps_d3_wr = wr_pmcsr & (hwdata_i[1:0] == plpsc_pkg::PS_D3) & in_d0; // R9
  assign ps_d0_wr = wr_pmcsr & (hwdata_i[1:0] == plpsc_pkg::PS_D0) &
                    (dstate_r == plpsc_pkg::DSTATE_D3);
  assign en_wr    = wr_cmd & (hwdata_i[plpsc_pkg::CMD_IO_BIT] |
                    hwdata_i[plpsc_pkg::CMD_MEM_BIT]);

  always_comb
  begin
    dstate_nxt = dstate_r;
    if (!hrst_s)
      dstate_nxt = plpsc_pkg::HELD_IN_RESET_STATE; // R18
    else
      unique case (dstate_r)
        plpsc_pkg::HELD_IN_RESET_STATE:
          if (hrst_rise)
            dstate_nxt = plpsc_pkg::FULL_POWER_UNINITIALISED; // R19
        plpsc_pkg::FULL_POWER_UNINITIALISED:
          if (ps_d3_wr)
            dstate_nxt = plpsc_pkg::DSTATE_D3;
          else if (en_wr)
            dstate_nxt = plpsc_pkg::FULL_POWER_ACTIVE; // R11 R12
        plpsc_pkg::FULL_POWER_ACTIVE:
          if (ps_d3_wr)
            dstate_nxt = plpsc_pkg::DSTATE_D3;
        plpsc_pkg::DSTATE_D3:
          if (ps_d0_wr)
            dstate_nxt = plpsc_pkg::FULL_POWER_UNINITIALISED; // R10 R22
        default:
          dstate_nxt = plpsc_pkg::HELD_IN_RESET_STATE;
      endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      dstate_r    <= plpsc_pkg::HELD_IN_RESET_STATE;
      go_l2_r     <= 1'b0;
      hrst_prev_r <= 1'b0;
    end
    else
    begin
      dstate_r    <= dstate_nxt;
      hrst_prev_r <= hrst_s;
      if (dstate_nxt == plpsc_pkg::HELD_IN_RESET_STATE &&
          dstate_r != plpsc_pkg::HELD_IN_RESET_STATE)
        go_l2_r <= (dstate_r == plpsc_pkg::DSTATE_D3) & pme_en_r; // R4 R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge mclk_i)
  begin
    if (cfg_rst)
    begin
      aspm_r   <= plpsc_pkg::ASPM_RST; // R6
      io_en_r  <= 1'b0;
      mem_en_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        aspm_r <= hwdata_i[plpsc_pkg::CTRL_ASPM_LSB +: 2];
      if (wr_cmd)
      begin
        io_en_r  <= hwdata_i[plpsc_pkg::CMD_IO_BIT];
        mem_en_r <= hwdata_i[plpsc_pkg::CMD_MEM_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link power state and idle timer

  plpsc_pkg::plpsc_lstate_t lstate_r;
  plpsc_pkg::plpsc_lstate_t lstate_nxt;
  logic [LAT_W-1:0]         idle_cnt_r;
  wire logic                idle_max;
  wire logic                l0s_hit;
  wire logic                l1_hit;
  wire logic                idle_clr;

  assign idle_max = &idle_cnt_r;
  assign l0s_hit  = aspm_r[0] & (idle_cnt_r > idle_to_standby_latency_i) & ~link_traffic_i; // R7
  assign l1_hit   = aspm_r[1] & (idle_cnt_r >= standby_to_sleep_latency_i) & ~link_traffic_i; // R8
  assign idle_clr = link_traffic_i | (lstate_nxt != lstate_r) | ~in_d0; // R21

  always_comb
  begin
    lstate_nxt = lstate_r;
    if (dstate_r == plpsc_pkg::HELD_IN_RESET_STATE)
      lstate_nxt = go_l2_r ? plpsc_pkg::LINK_L2 : plpsc_pkg::LINK_L3; // R4 R5
    else if (dstate_r == plpsc_pkg::DSTATE_D3)
      lstate_nxt = plpsc_pkg::LINK_L1; // R3
    else
      unique case (lstate_r)
        plpsc_pkg::LINK_L0:
          if (l0s_hit)
            lstate_nxt = plpsc_pkg::LINK_L0S; // R2
        plpsc_pkg::LINK_L0S:
          if (link_traffic_i)
            lstate_nxt = plpsc_pkg::LINK_L0; // R21
          else if (l1_hit)
            lstate_nxt = plpsc_pkg::LINK_L1; // R3
        plpsc_pkg::LINK_L1:
          if (link_traffic_i || !aspm_r[1])
            lstate_nxt = plpsc_pkg::LINK_L0; // R21
        default:
          lstate_nxt = plpsc_pkg::LINK_L0; // R1
      endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      lstate_r   <= plpsc_pkg::LINK_L3;
      idle_cnt_r <= '0;
    end
    else
    begin
      lstate_r <= lstate_nxt;
      if (idle_clr)
        idle_cnt_r <= '0; // R21
      else if (!idle_max)
        idle_cnt_r <= idle_cnt_r + 1'b1;
    end
  end

  assign link_ready_o = in_d0 & (lstate_r == plpsc_pkg::LINK_L0); // R1 R21

  ////////////////////////////////////////////////////////////////////////////
  // power-up and reset release sequencing

  wire logic lan_done;
  wire logic pg_done;
  logic      lan_pg_r;
  logic      int_pg_r;
  logic      phy_rst_r;
  logic      phy_full_r;
  wire logic pg_rise;

  plpsc_delay #(.CYC (PPG_CYC)) u_lan_dly (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .run_i   (supply_s & osc_s),
    .done_o  (lan_done)
  );

  plpsc_delay #(.CYC (CLKPR_CYC)) u_pg_dly (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .run_i   (hrst_s),
    .done_o  (pg_done)
  );

  plpsc_delay #(.CYC (PGTRN_CYC)) u_trn_dly (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .run_i   (hrst_s),
    .done_o  (seq_o.link_train) // R16
  );

  plpsc_delay #(.CYC (PGCFG_CYC)) u_cfg_dly (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .run_i   (hrst_s),
    .done_o  (seq_o.cfg_accept) // R17
  );

  plpsc_delay #(.CYC (PGRES_CYC)) u_res_dly (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .run_i   (hrst_s),
    .done_o  (seq_o.cfg_resp) // R17
  );

  assign pg_rise = pg_done & clk_ok_s & ~int_pg_r;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      lan_pg_r   <= 1'b0;
      int_pg_r   <= 1'b0;
      phy_rst_r  <= 1'b0;
      wake_en_r  <= 1'b0;
      pme_en_r   <= 1'b0;
      phy_full_r <= 1'b0;
    end
    else
    begin
      lan_pg_r  <= lan_done & supply_s; // R13
      int_pg_r  <= pg_done & clk_ok_s; // R15
      phy_rst_r <= pg_rise; // R20
      if (pg_rise)
        wake_en_r <= 1'b0; // R20
      else if (wr_ctrl)
        wake_en_r <= hwdata_i[plpsc_pkg::CTRL_WAKE_BIT];
      if (wr_ctrl)
        pme_en_r <= hwdata_i[plpsc_pkg::CTRL_PME_BIT];
      if (dstate_r == plpsc_pkg::FULL_POWER_UNINITIALISED &&
          dstate_nxt == plpsc_pkg::FULL_POWER_ACTIVE)
        phy_full_r <= 1'b1; // R11
      else if (dstate_nxt == plpsc_pkg::DSTATE_D3 ||
               dstate_nxt == plpsc_pkg::HELD_IN_RESET_STATE)
        phy_full_r <= 1'b0;
    end
  end

  assign lan_power_good_o             = lan_pg_r;
  assign seq_o.internal_link_power_ok = int_pg_r;
  assign seq_o.phy_reset              = phy_rst_r;
  assign wake_enable_o                = wake_en_r;
  assign phy_full_power_o             = phy_full_r;
  assign dstate_o                     = dstate_r;
  assign lstate_o                     = lstate_r;

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  wire logic [1:0]  ps_field;
  wire logic [31:0] status_word;

  assign ps_field    = (dstate_r == plpsc_pkg::DSTATE_D3) ? plpsc_pkg::PS_D3 : plpsc_pkg::PS_D0;
  assign status_word = {18'h0, seq_o, lstate_r, dstate_r};
  assign rd_word     =
    (haddr_i[7:0] == plpsc_pkg::OFS_CTRL)   ? {28'h0, wake_en_r, pme_en_r, aspm_r} :
    (haddr_i[7:0] == plpsc_pkg::OFS_PMCSR)  ? {30'h0, ps_field} :
    (haddr_i[7:0] == plpsc_pkg::OFS_CMD)    ? {30'h0, mem_en_r, io_en_r} :
    (haddr_i[7:0] == plpsc_pkg::OFS_LAT)    ? {16'(standby_to_sleep_latency_i),
                                               16'(idle_to_standby_latency_i)} :
    (haddr_i[7:0] == plpsc_pkg::OFS_STATUS) ? status_word : 32'h0000_0000;

endmodule
`default_nettype wire

// >>> sim/plpsc_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module plpsc_ctrl_assertions #(
  parameter int unsigned PPG_CYC   = 20,
  parameter int unsigned CLKPR_CYC = 5,
  parameter int unsigned PGTRN_CYC = 30,
  parameter int unsigned PGRES_CYC = 45
) (
  input wire logic                     mclk_i,
  input wire logic                     rst_n_i,
  input wire logic                     host_fundamental_reset_n_i,
  input wire logic                     supplies_good_i,
  input wire logic                     osc_stable_i,
  input wire logic                     link_traffic_i,
  input wire logic                     lan_power_good_o,
  input wire plpsc_pkg::plpsc_seq_t    seq_o,
  input wire plpsc_pkg::plpsc_dstate_t dstate_o,
  input wire plpsc_pkg::plpsc_lstate_t lstate_o,
  input wire logic                     wake_enable_o
);
  int unsigned rel_cnt_r;
  int unsigned pwr_cnt_r;
  wire         d0_w = dstate_o inside {plpsc_pkg::FULL_POWER_UNINITIALISED,
                                       plpsc_pkg::FULL_POWER_ACTIVE};
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////
  // cycles since pin release and since supplies good and oscillator stable
  always_ff @(posedge mclk_i)
  begin
    rel_cnt_r <= (!rst_n_i || !host_fundamental_reset_n_i) ? 0 : rel_cnt_r + 1;
    pwr_cnt_r <= (!rst_n_i || !(supplies_good_i && osc_stable_i)) ? 0 : pwr_cnt_r + 1;
  end
  a_d3_link_sleep: assert property
    (dstate_o == plpsc_pkg::DSTATE_D3 |=> lstate_o == plpsc_pkg::LINK_L1)
    else $error("link not L1 in D3");
  a_active_to_l3: assert property
    (dstate_o == plpsc_pkg::FULL_POWER_ACTIVE ##1 dstate_o == plpsc_pkg::HELD_IN_RESET_STATE
     |=> lstate_o == plpsc_pkg::LINK_L3)
    else $error("reset from active not L3");
  a_traffic_wakes: assert property
    (link_traffic_i && d0_w |=> lstate_o == plpsc_pkg::LINK_L0)
    else $error("traffic left link idle");
  a_standby_idle: assert property
    (lstate_o == plpsc_pkg::LINK_L0 ##1 lstate_o == plpsc_pkg::LINK_L0S
     |-> !$past(link_traffic_i) && !$past(link_traffic_i, 2))
    else $error("standby entered with traffic");
  a_sleep_via_standby: assert property
    (lstate_o == plpsc_pkg::LINK_L1 && $past(lstate_o) != plpsc_pkg::LINK_L1 && $past(d0_w)
     |-> $past(lstate_o) == plpsc_pkg::LINK_L0S)
    else $error("sleep not via standby");
  a_pok_phy_reset: assert property
    ($rose(seq_o.internal_link_power_ok) |-> rel_cnt_r >= CLKPR_CYC
     ##[0:1] (seq_o.phy_reset && !wake_enable_o))
    else $error("power ok sequence wrong");
  a_train_delay: assert property
    ($rose(seq_o.link_train) |-> rel_cnt_r >= PGTRN_CYC && rel_cnt_r <= PGTRN_CYC + 6)
    else $error("training delay wrong");
  a_cfg_delay: assert property
    ($rose(seq_o.cfg_resp) |-> seq_o.cfg_accept && rel_cnt_r >= PGRES_CYC)
    else $error("config response early");
  a_lan_pg_delay: assert property
    ($rose(lan_power_good_o) |-> pwr_cnt_r >= PPG_CYC && pwr_cnt_r <= PPG_CYC + 6)
    else $error("lan power good delay wrong");
  a_release_uninit: assert property
    ($rose(host_fundamental_reset_n_i) |-> ##[1:4]
     dstate_o == plpsc_pkg::FULL_POWER_UNINITIALISED)
    else $error("stuck after release");
  a_assert_held: assert property
    ($fell(host_fundamental_reset_n_i) |-> ##[1:4] dstate_o == plpsc_pkg::HELD_IN_RESET_STATE)
    else $error("no reset state on pin");
endmodule

bind plpsc_ctrl plpsc_ctrl_assertions #(
  .PPG_CYC(PPG_CYC), .CLKPR_CYC(CLKPR_CYC), .PGTRN_CYC(PGTRN_CYC), .PGRES_CYC(PGRES_CYC)
) plpsc_ctrl_assertions_inst (
  .mclk_i, .rst_n_i, .host_fundamental_reset_n_i, .supplies_good_i, .osc_stable_i,
  .link_traffic_i, .lan_power_good_o, .seq_o, .dstate_o, .lstate_o, .wake_enable_o);
`default_nettype wire

// >>> sim/plpsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module plpsc_host_model (
  input  wire logic mclk_i,
  input  wire logic power_on_i,
  input  wire logic reset_req_i,
  input  wire logic slow_i,
  output logic      host_fundamental_reset_n_o,
  output logic      supplies_good_o,
  output logic      osc_stable_o,
  output logic      pcie_clk_stable_o
);
  logic [7:0] pwr_cnt_r = 8'h00;
  logic [7:0] rel_cnt_r = 8'h00;
  wire  [7:0] lead_w    = slow_i ? 8'h28 : 8'h0a;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i)
  begin
    pwr_cnt_r <= !power_on_i ? 8'h00 : pwr_cnt_r + {7'h00, pwr_cnt_r != 8'hff};
    rel_cnt_r <= (!osc_stable_o || reset_req_i) ? 8'h00 : rel_cnt_r + {7'h00, rel_cnt_r != 8'hff};
  end
  assign supplies_good_o            = pwr_cnt_r >= 8'h04;
  assign osc_stable_o               = pwr_cnt_r >= 8'h08;
  // release only after power stable for lead cycles; refclock stable follows 3 cycles after release
  assign host_fundamental_reset_n_o = rel_cnt_r >= lead_w;
  assign pcie_clk_stable_o          = rel_cnt_r >= lead_w + 8'h03;
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                     mclk_i = 1'b0;
  logic                     rst_n_i = 1'b0;
  logic                     hsel_i = 1'b1;
  logic [31:0]              haddr_i = 32'h0;
  logic [1:0]               htrans_i = 2'h0;
  logic                     hwrite_i = 1'b0;
  logic [2:0]               hsize_i = 3'h2;
  logic [31:0]              hwdata_i = 32'h0;
  logic [15:0]              idle_to_standby_latency_i = 16'h0003;
  logic [15:0]              standby_to_sleep_latency_i = 16'h0004;
  logic                     link_traffic_i = 1'b1;
  logic                     power_on = 1'b0;
  logic                     reset_req = 1'b1;
  logic                     slow = 1'b0;
  wire                      host_fundamental_reset_n_i, supplies_good_i;
  wire                      osc_stable_i, pcie_clk_stable_i;
  logic [31:0]              hrdata_o;
  logic                     hreadyout_o, hresp_o, lan_power_good_o;
  logic                     link_ready_o, phy_full_power_o, wake_enable_o;
  plpsc_pkg::plpsc_seq_t    seq_o;
  plpsc_pkg::plpsc_dstate_t dstate_o;
  plpsc_pkg::plpsc_lstate_t lstate_o;
  int                       errors = 0;
  int                       n_tests = 0;
  logic [31:0]              seed = 32'h339d741b;
  logic [31:0]              rd;

  always #2 mclk_i = ~mclk_i;

  plpsc_ctrl #(.PPG_CYC(20), .CLKPR_CYC(5), .PGTRN_CYC(30), .PGCFG_CYC(40), .PGRES_CYC(45))
  plpsc_ctrl_inst (
    .mclk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .host_fundamental_reset_n_i,
    .supplies_good_i, .osc_stable_i, .pcie_clk_stable_i, .idle_to_standby_latency_i,
    .standby_to_sleep_latency_i, .link_traffic_i, .lan_power_good_o, .seq_o, .dstate_o,
    .lstate_o, .link_ready_o, .phy_full_power_o, .wake_enable_o);

  plpsc_host_model plpsc_host_model_inst (
    .mclk_i, .power_on_i(power_on), .reset_req_i(reset_req), .slow_i(slow),
    .host_fundamental_reset_n_o(host_fundamental_reset_n_i), .supplies_good_o(supplies_good_i),
    .osc_stable_o(osc_stable_i), .pcie_clk_stable_o(pcie_clk_stable_i));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [31:0] stat_exp(input logic [4:0] sq, input logic [4:0] ls,
                                           input logic [3:0] ds);
    return {18'h0, sq, ls, ds};
  endfunction

  function automatic logic [4:0] rst_link(input logic from_d3, input logic pme);
    return (from_d3 && pme) ? plpsc_pkg::LINK_L2 : plpsc_pkg::LINK_L3;
  endfunction

  task automatic wrap_up;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tmo(input string n);
    errors++;
    $display("Error %s expected done seen timeout", n);
    wrap_up;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    htrans_i <= 2'h2;
    haddr_i  <= {24'h0, a};
    hwrite_i <= wr;
    i = 0;
    do
    begin
      @(posedge mclk_i);
      i++;
      if (i > 50) tmo("ahb");
    end while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do
    begin
      @(posedge mclk_i);
      i++;
      if (i > 100) tmo("ahb");
    end while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    chk("hresp", 0, hresp_o);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  task automatic wait_st(input logic [4:0] ls, input logic [3:0] ds, output int n);
    n = 0;
    while (!((ls == 0 || lstate_o === ls) && (ds == 0 || dstate_o === ds)))
    begin
      @(posedge mclk_i);
      n++;
      if (n > 600) tmo("state");
    end
  endtask

  task automatic boot;
    int n;
    reset_req <= 1'b0;
    wait_st(0, plpsc_pkg::FULL_POWER_UNINITIALISED, n);
    while (seq_o.cfg_resp !== 1'b1)
    begin
      @(posedge mclk_i);
      n++;
      if (n > 800) tmo("boot");
    end
  endtask

  task automatic idle_test(input logic [1:0] aspm);
    int n;
    seed = xs(seed);
    idle_to_standby_latency_i  <= {13'h0, seed[2:0]};
    standby_to_sleep_latency_i <= {12'h0, seed[7:4]};
    wr(plpsc_pkg::OFS_CTRL, {30'h0, aspm});
    link_traffic_i <= 1'b0;
    wait_st(plpsc_pkg::LINK_L0S, 0, n);
    chk("l0s_wait", 1, (n - idle_to_standby_latency_i) inside {[2:4]});
    if (aspm[1])
    begin
      wait_st(plpsc_pkg::LINK_L1, 0, n);
      chk("l1_wait", 1, (n - standby_to_sleep_latency_i) inside {[0:3]});
    end
    else
    begin
      repeat (24) @(posedge mclk_i);
      chk("l0s_stay", plpsc_pkg::LINK_L0S, lstate_o);
    end
    link_traffic_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk("l0_back", plpsc_pkg::LINK_L0, lstate_o);
    chk("link_ready", 1, link_ready_o);
  endtask

  initial
  begin
    int n;
    int k;
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    rd_chk("status", plpsc_pkg::OFS_STATUS,
           stat_exp(5'h00, plpsc_pkg::LINK_L3, plpsc_pkg::HELD_IN_RESET_STATE));
    rd_chk("ctrl", plpsc_pkg::OFS_CTRL, 32'h0);
    rd_chk("unmapped", 8'h14, 32'h0);
    rd_chk("lat", plpsc_pkg::OFS_LAT, 32'h00040003);
    power_on <= 1'b1;
    repeat (12) @(posedge mclk_i);
    chk("lan_pg_early", 0, lan_power_good_o);
    boot;
    chk("lan_pg", 1, lan_power_good_o);
    rd_chk("status", plpsc_pkg::OFS_STATUS,
           stat_exp(5'h17, plpsc_pkg::LINK_L0, plpsc_pkg::FULL_POWER_UNINITIALISED));
    idle_test(2'h1);
    wr(plpsc_pkg::OFS_CMD, 32'h1);
    wait_st(0, plpsc_pkg::FULL_POWER_ACTIVE, n);
    chk("phy_full", 1, phy_full_power_o);
    repeat (3) idle_test(2'h3);
    wr(plpsc_pkg::OFS_PMCSR, 32'h3);
    wait_st(plpsc_pkg::LINK_L1, plpsc_pkg::DSTATE_D3, n);
    chk("d3_time", 1, n <= 6);
    rd_chk("pmcsr", plpsc_pkg::OFS_PMCSR, 32'h3);
    wr(plpsc_pkg::OFS_CMD, 32'h2);
    repeat (5) @(posedge mclk_i);
    chk("d3_hold", plpsc_pkg::DSTATE_D3, dstate_o);
    wr(plpsc_pkg::OFS_PMCSR, 32'h0);
    wait_st(0, plpsc_pkg::FULL_POWER_UNINITIALISED, n);
    seed = xs(seed);
    repeat (seed[5:0]) @(posedge mclk_i);
    chk("uninit_hold", plpsc_pkg::FULL_POWER_UNINITIALISED, dstate_o);
    rd_chk("pmcsr", plpsc_pkg::OFS_PMCSR, 32'h0);
    wr(plpsc_pkg::OFS_CMD, 32'h2);
    wait_st(0, plpsc_pkg::FULL_POWER_ACTIVE, n);
    for (k = 0; k < 3; k++)
    begin
      slow <= k[1];
      wr(plpsc_pkg::OFS_CTRL, {28'h0, 1'b1, k != 1, 2'h3});
      @(posedge mclk_i);
      chk("wake_on", 1, wake_enable_o);
      if (k > 0)
      begin
        wr(plpsc_pkg::OFS_PMCSR, 32'h3);
        wait_st(plpsc_pkg::LINK_L1, plpsc_pkg::DSTATE_D3, n);
      end
      reset_req <= 1'b1;
      wait_st(rst_link(k > 0, k != 1), plpsc_pkg::HELD_IN_RESET_STATE, n);
      chk("rst_time", 1, n <= 16);
      rd_chk("ctrl_rst", plpsc_pkg::OFS_CTRL, {28'h0, 1'b1, k != 1, 2'h0});
      boot;
      chk("wake_off", 0, wake_enable_o);
      wr(plpsc_pkg::OFS_CMD, 32'h1);
      wait_st(0, plpsc_pkg::FULL_POWER_ACTIVE, n);
    end
    wrap_up;
  end
endmodule
`default_nettype wire
